// file: bac_barrier_arm_map.svh
// Constants for the barrier arm controller: input slots, switch bits, timing.
// Assumes a 40 MHz system clock; included by the package and the top module.
`ifndef BAC_BARRIER_ARM_MAP_SVH
`define BAC_BARRIER_ARM_MAP_SVH
// ==========================================
// Clock and timing
`define BAC_CLK_HZ 40000000
`define BAC_DEBOUNCE_MS 10
`define BAC_DEBOUNCE_CYC ((`BAC_CLK_HZ / 1000) * `BAC_DEBOUNCE_MS)
`define BAC_SEC_S 1
`define BAC_SEC_CYC (`BAC_CLK_HZ * `BAC_SEC_S)
`define BAC_AC_MAX_S 7'h7c
// ==========================================
// Contact input slots in the debounce bank
`define BAC_IN_OPEN 0
`define BAC_IN_CLOSE 1
`define BAC_IN_STOP 2
`define BAC_IN_SINGLE 3
`define BAC_IN_REV 4
`define BAC_IN_RHOLD 5
`define BAC_IN_OBST 6
`define BAC_IN_LOOP 7
`define BAC_IN_UPLIM 8
`define BAC_IN_DNLIM 9
`define BAC_IN_LOPEN 10
`define BAC_IN_LCLOSE 11
`define BAC_IN_NUM 12
// ==========================================
// Option switch bit positions
`define BAC_SW_AUTOCLOSE 0
`define BAC_SW_LATCH 1
`define BAC_SW_SEQ 2
`define BAC_SW_NOCOUNT 3
`define BAC_SW_NOPAUSE 4
`define BAC_SW_NOBRAKE 5
`define BAC_SW_SLAVE 7
// ==========================================
// Reset values and counter limit
`define BAC_COUNT_RST 8'h00
`define BAC_COUNT_MAX 8'hff
`define BAC_PHASE_RST 2'h0
`endif

// file: bac_pkg.sv
// Types shared by the barrier arm controller.
// Assumes the map header is on the include path.
`include "bac_barrier_arm_map.svh"
package bac_pkg;
   // ==========================================
   // Arm motion states
   typedef enum logic [1:0] {
      BAC_IDLE,
      BAC_RAISE,
      BAC_LOWER,
      BAC_PAUSE
   } bac_state_t;
endpackage

// file: bac_barrier_arm_controller.sv
// Barrier arm operator control: inputs, option switches, motor and run outputs.
// Assumes contact inputs are raw levels, active high, and an analog current
// reading digitised elsewhere onto motor_current.
`timescale 1ns/1ps
`include "bac_barrier_arm_map.svh"
module bac_barrier_arm_controller
   import bac_pkg::*;
#(
   parameter int DEBOUNCE_CYCLES = `BAC_DEBOUNCE_CYC,
   parameter int SEC_CYCLES = `BAC_SEC_CYC
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic open_in,
   input wire logic close_in,
   input wire logic stop_in,
   input wire logic single_in,
   input wire logic reverse_in,
   input wire logic raise_hold_in,
   input wire logic close_obst_in,
   input wire logic reset_loop_in,
   input wire logic up_limit_switch,
   input wire logic down_limit_switch,
   input wire logic link_open_in,
   input wire logic link_close_in,
   input wire logic [7:0] option_sw,
   input wire logic battery_variant,
   input wire logic [6:0] autoclose_delay_s,
   input wire logic [9:0] motor_current,
   input wire logic [9:0] current_threshold,
   output logic motor_up,
   output logic motor_down,
   output logic run_out,
   output logic brake_on,
   output logic link_open_out,
   output logic link_close_out,
   output logic close_lockout,
   output logic [7:0] vehicle_count
);

   // ==========================================
   // Helpers
   function automatic logic is_moving(input bac_state_t s);
      is_moving = (s == BAC_RAISE) || (s == BAC_LOWER);
   endfunction

   // ==========================================
   // Input conditioning
   logic [`BAC_IN_NUM-1:0] raw;
   logic [`BAC_IN_NUM-1:0] sync1;
   logic [`BAC_IN_NUM-1:0] sync2;
   logic [`BAC_IN_NUM-1:0] clean;
   logic [`BAC_IN_NUM-1:0] clean_d;
   logic [`BAC_IN_NUM-1:0] rise;
   logic [`BAC_IN_NUM-1:0] fall;

   // Raw contact bank
   assign raw = {link_close_in, link_open_in, down_limit_switch, up_limit_switch, reset_loop_in,
                 close_obst_in, raise_hold_in, reverse_in, single_in, stop_in, close_in, open_in};

   // Two-flop sync then stability filter per input
   for (genvar g = 0; g < `BAC_IN_NUM; g++) begin : g_deb
      logic [19:0] deb_cnt;
      always_ff @(posedge clk_sys or posedge sys_rst) begin
         if (sys_rst) begin
            sync1[g] <= 1'b0;
            sync2[g] <= 1'b0;
            clean[g] <= 1'b0;
            deb_cnt <= 20'h00000;
         end else begin
            sync1[g] <= raw[g];
            sync2[g] <= sync1[g];
            if (sync2[g] == clean[g]) begin
               deb_cnt <= 20'h00000;
            end else if (deb_cnt >= 20'(DEBOUNCE_CYCLES - 1)) begin
               clean[g] <= sync2[g];
               deb_cnt <= 20'h00000;
            end else begin
               deb_cnt <= deb_cnt + 20'h00001;
            end
         end
      end
   end

   // Edge history of clean levels
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         clean_d <= '0;
      end else begin
         clean_d <= clean;
      end
   end

   assign rise = clean & ~clean_d;
   assign fall = ~clean & clean_d;

   // ==========================================
   // State and storage
   bac_state_t state;
   bac_state_t next_state;
   logic latch;
   logic next_latch;
   logic lockout;
   logic next_lockout;
   logic [7:0] count;
   logic [7:0] next_count;
   logic [1:0] phase;
   logic [25:0] sec_cnt;
   logic [6:0] secs;
   logic over_cur;

   // ==========================================
   // Command decode
   wire slave = option_sw[`BAC_SW_SLAVE];
   wire sw_ac = option_sw[`BAC_SW_AUTOCLOSE];
   wire sw_latch = option_sw[`BAC_SW_LATCH];
   wire sw_seq = option_sw[`BAC_SW_SEQ];
   wire up_lim = clean[`BAC_IN_UPLIM];
   wire dn_lim = clean[`BAC_IN_DNLIM];
   wire stop_lvl = clean[`BAC_IN_STOP];
   wire loop_lvl = clean[`BAC_IN_LOOP];
   wire hold_raw = clean[`BAC_IN_RHOLD];
   wire count_en = !option_sw[`BAC_SW_NOCOUNT] && !sw_latch;
   wire sb_hit = rise[`BAC_IN_SINGLE];
   wire sb_open = sb_hit && (sw_seq ? (phase == 2'h0) : !up_lim);
   wire sb_close = sb_hit && (sw_seq ? (phase == 2'h2) : up_lim);
   wire sb_stop = sb_hit && sw_seq && phase[0];
   wire ext_open = slave ? rise[`BAC_IN_LOPEN] : rise[`BAC_IN_OPEN];
   wire ext_close = slave ? rise[`BAC_IN_LCLOSE] : rise[`BAC_IN_CLOSE];
   wire hold_lvl = !sw_latch && hold_raw;
   wire latch_set = sw_latch && rise[`BAC_IN_RHOLD] && !latch;
   wire latch_drop = sw_latch && rise[`BAC_IN_RHOLD] && latch;
   wire reset_evt = rise[`BAC_IN_STOP] || fall[`BAC_IN_LOOP];
   wire open_any = ext_open || sb_open || latch_set || (!sw_latch && rise[`BAC_IN_RHOLD]);
   wire count_clear = !count_en || (count <= 8'h01);
   wire lower_evt = (fall[`BAC_IN_LOOP] && count_clear) || (!sw_latch && fall[`BAC_IN_RHOLD]) ||
                    latch_drop;
   wire [6:0] ac_delay = (autoclose_delay_s > `BAC_AC_MAX_S) ? `BAC_AC_MAX_S : autoclose_delay_s;
   wire ac_ok = sw_ac && (state == BAC_IDLE) && up_lim && !clean[`BAC_IN_OPEN] &&
                !clean[`BAC_IN_REV] && !clean[`BAC_IN_OBST] && !hold_raw && !latch &&
                !(count_en && (count != 8'h00)) && !lockout;
   wire ac_fire = ac_ok && (secs >= ac_delay);
   wire close_req = (ext_close || sb_close || ac_fire || lower_evt) && !lockout && !hold_lvl &&
                    !(latch && !latch_drop && !reset_evt);
   wire open_req = open_any || hold_lvl || latch;
   wire lowering = (state == BAC_LOWER);
   wire obst_trip = lowering && (clean[`BAC_IN_REV] || clean[`BAC_IN_OBST] || over_cur);
   wire pause_req = loop_lvl && !option_sw[`BAC_SW_NOPAUSE];
   wire brake_allow = !(battery_variant && option_sw[`BAC_SW_NOBRAKE]);

   // ==========================================
   // Motion state decision
   always_comb begin
      next_state = state;
      if (stop_lvl || sb_stop) begin
         next_state = BAC_IDLE;
      end else if (obst_trip) begin
         next_state = BAC_RAISE;
      end else begin
         case (state)
            BAC_IDLE: begin
               if (open_req && !up_lim) begin
                  next_state = BAC_RAISE;
               end else if (close_req && !dn_lim) begin
                  next_state = BAC_LOWER;
               end
            end
            BAC_RAISE: begin
               if (up_lim) begin
                  next_state = BAC_IDLE;
               end
            end
            BAC_LOWER: begin
               if (dn_lim) begin
                  next_state = BAC_IDLE;
               end else if (open_req) begin
                  next_state = BAC_RAISE;
               end else if (pause_req) begin
                  next_state = BAC_PAUSE;
               end
            end
            BAC_PAUSE: begin
               if (open_req) begin
                  next_state = BAC_RAISE;
               end else if (!loop_lvl || option_sw[`BAC_SW_NOPAUSE]) begin
                  next_state = BAC_LOWER;
               end
            end
            default: begin
               next_state = BAC_IDLE;
            end
         endcase
      end
   end

   // Latch, lockout and counter next values
   always_comb begin
      next_latch = latch;
      if (!sw_latch || latch_drop || reset_evt) begin
         next_latch = 1'b0;
      end else if (latch_set) begin
         next_latch = 1'b1;
      end
      next_lockout = lockout;
      if (lowering && over_cur && !stop_lvl) begin
         next_lockout = 1'b1;
      end else if (rise[`BAC_IN_STOP]) begin
         next_lockout = 1'b0;
      end
      next_count = count;
      if (!count_en) begin
         next_count = `BAC_COUNT_RST;
      end else if (open_any && !(reset_evt && count != 8'h00)) begin
         next_count = (count == `BAC_COUNT_MAX) ? count : count + 8'h01;
      end else if (reset_evt && !open_any && count != 8'h00) begin
         next_count = count - 8'h01;
      end
   end

   // ==========================================
   // Registers
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state <= BAC_IDLE;
         latch <= 1'b0;
         lockout <= 1'b0;
         count <= `BAC_COUNT_RST;
      end else begin
         state <= next_state;
         latch <= next_latch;
         lockout <= next_lockout;
         count <= next_count;
      end
   end

   // Single button sequence phase
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         phase <= `BAC_PHASE_RST;
      end else if (sb_hit && sw_seq) begin
         phase <= phase + 2'h1;
      end
   end

   // Current comparator, registered
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         over_cur <= 1'b0;
      end else begin
         over_cur <= lowering && (motor_current > current_threshold);
      end
   end

   // Auto-close seconds timer, restarts whenever conditions break
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sec_cnt <= 26'h0000000;
         secs <= 7'h00;
      end else if (!ac_ok) begin
         sec_cnt <= 26'h0000000;
         secs <= 7'h00;
      end else if (sec_cnt >= 26'(SEC_CYCLES - 1)) begin
         sec_cnt <= 26'h0000000;
         secs <= (secs == 7'h7f) ? secs : secs + 7'h01;
      end else begin
         sec_cnt <= sec_cnt + 26'h0000001;
      end
   end

   // Output flops follow the next state so they line up with state
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         motor_up <= 1'b0;
         motor_down <= 1'b0;
         run_out <= 1'b0;
         brake_on <= 1'b0;
         link_open_out <= 1'b0;
         link_close_out <= 1'b0;
         close_lockout <= 1'b0;
         vehicle_count <= `BAC_COUNT_RST;
      end else begin
         motor_up <= (next_state == BAC_RAISE);
         motor_down <= (next_state == BAC_LOWER);
         run_out <= is_moving(next_state);
         brake_on <= !is_moving(next_state) && brake_allow;
         link_open_out <= !slave && (next_state == BAC_RAISE);
         link_close_out <= !slave && (next_state == BAC_LOWER);
         close_lockout <= next_lockout;
         vehicle_count <= next_count;
      end
   end

   // ==========================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   a_run_tracks_motor: assert property (run_out == (motor_up || motor_down))
      else $error("run output disagrees with motor drive");
   a_no_both_dirs: assert property (!(motor_up && motor_down))
      else $error("motor driven both ways");
   a_stop_halts: assert property (stop_lvl |=> !motor_up && !motor_down)
      else $error("stop did not halt motor");
   a_up_limit_stop: assert property (state == BAC_RAISE && up_lim && !obst_trip |=> !motor_up)
      else $error("raise continued past up limit");
   a_obst_reverses: assert property (lowering && clean[`BAC_IN_OBST] && !stop_lvl && !sb_stop
                                     |=> motor_up && !motor_down)
      else $error("obstruction did not reverse arm");
   a_rev_reverses: assert property (lowering && clean[`BAC_IN_REV] && !stop_lvl && !sb_stop |=> state == BAC_RAISE)
      else $error("reverse input ignored while lowering");
   a_lockout_blocks: assert property (lockout && state == BAC_IDLE && !obst_trip |=> state != BAC_LOWER)
      else $error("close accepted during lockout");
   a_brake_disable: assert property (battery_variant && option_sw[`BAC_SW_NOBRAKE] |=> !brake_on)
      else $error("brake on while disabled");
   a_pause_on_loop: assert property (lowering && pause_req && !stop_lvl && !sb_stop && !obst_trip &&
                                     !dn_lim && !open_req |=> state == BAC_PAUSE && !motor_down)
      else $error("descent not paused by reset loop");
   a_slave_silent: assert property (slave |=> !link_open_out && !link_close_out)
      else $error("slave drives link outputs");
   a_ac_off: assert property (!sw_ac && state == BAC_IDLE && up_lim && !ext_close && !sb_close &&
                              !lower_evt |=> !motor_down)
      else $error("auto-close fired while disabled");
   a_count_off: assert property (sw_latch |=> vehicle_count == 8'h00)
      else $error("counting active with latch mode");

   c_raise_full: cover property (motor_up ##[1:1000] !motor_up && up_lim);
   c_obst_trip: cover property (lowering && over_cur ##1 motor_up);
   c_pause_resume: cover property (state == BAC_PAUSE ##[1:1000] state == BAC_LOWER);

endmodule // bac_barrier_arm_controller

// file: bac_arm_model.sv
// Behavioural arm with up and down limit switches for the controller bench.
// Assumes the arm starts fully closed and moves one step per clock while driven.
`timescale 1ns/1ps
module bac_arm_model #(
   parameter int TRAVEL = 30
) (
   input wire logic clk_sys,
   input wire logic motor_up,
   input wire logic motor_down,
   output logic up_limit_switch,
   output logic down_limit_switch
);
   // ==========================================
   // Arm position, clamped at both ends
   int pos = 0;
   always @(posedge clk_sys) begin
      if (motor_up && pos < TRAVEL) begin
         pos <= pos + 1;
      end else if (motor_down && pos > 0) begin
         pos <= pos - 1;
      end
   end
   // Switch levels follow the end positions
   assign up_limit_switch = (pos == TRAVEL);
   assign down_limit_switch = (pos == 0);
endmodule // bac_arm_model

// file: tb_barrier_arm_controller.sv
// Self-checking bench for the barrier arm controller.
// Assumes short debounce and second counts set through the design parameters.
`timescale 1ns/1ps
module tb_barrier_arm_controller;
   import bac_pkg::*;
   localparam int DEB = 2;
   localparam int SEC = 20;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [9:0] cin = '0; // open close stop single rev hold obst loop lopen lclose
   logic [7:0] option_sw = 8'h08;
   logic battery_variant = 1'b0;
   logic [6:0] autoclose_delay_s = 7'h01;
   logic [9:0] motor_current = 10'h000;
   logic [9:0] current_threshold = 10'h200;
   logic up_lim, dn_lim, motor_up, motor_down, run_out, brake_on, lo_out, lc_out, close_lockout;
   logic [7:0] vehicle_count;
   logic [31:0] seed = 32'h00000b10;
   int errors = 0;
   int checks_done = 0;
   int n, d;
   int exp_count = 0; // Pending opens, per the counting rule
   int seq_q[$]; // Expected motor codes: bit 0 up, bit 1 down
   // ==========================================
   // Clock, design and arm
   initial forever #12.5 clk_sys = ~clk_sys;
   bac_barrier_arm_controller #(.DEBOUNCE_CYCLES(DEB), .SEC_CYCLES(SEC)) i_bac_barrier_arm_controller (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .open_in(cin[0]), .close_in(cin[1]), .stop_in(cin[2]),
      .single_in(cin[3]), .reverse_in(cin[4]), .raise_hold_in(cin[5]), .close_obst_in(cin[6]),
      .reset_loop_in(cin[7]), .up_limit_switch(up_lim), .down_limit_switch(dn_lim),
      .link_open_in(cin[8]), .link_close_in(cin[9]), .option_sw(option_sw),
      .battery_variant(battery_variant), .autoclose_delay_s(autoclose_delay_s),
      .motor_current(motor_current), .current_threshold(current_threshold), .motor_up(motor_up),
      .motor_down(motor_down), .run_out(run_out), .brake_on(brake_on), .link_open_out(lo_out),
      .link_close_out(lc_out), .close_lockout(close_lockout), .vehicle_count(vehicle_count));
   bac_arm_model #(.TRAVEL(30)) i_bac_arm_model (.clk_sys(clk_sys), .motor_up(motor_up),
      .motor_down(motor_down), .up_limit_switch(up_lim), .down_limit_switch(dn_lim));
   // ==========================================
   // Helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic set_in(input int idx, input logic v);
      @(posedge clk_sys);
      cin[idx] <= v;
   endtask
   task automatic press(input int idx);
      set_in(idx, 1'b1);
      repeat (DEB + 6) @(posedge clk_sys);
      set_in(idx, 1'b0);
      repeat (DEB + 2) @(posedge clk_sys);
   endtask
   // Wait for a motor state, bounded, then compare it and the run output
   task automatic wait_motor(input logic up, input logic dn, input int lim);
      int k;
      k = 0;
      while (!(motor_up === up && motor_down === dn) && k < lim) begin
         @(posedge clk_sys);
         #1;
         k++;
      end
      chk("motor_up", {7'h00, up}, {7'h00, motor_up});
      chk("motor_down", {7'h00, dn}, {7'h00, motor_down});
      chk("run_out", {7'h00, up | dn}, {7'h00, run_out});
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ==========================================
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      stop_test();
   end
   // ==========================================
   // Main sequence
   initial begin
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      #1;
      wait_motor(1'b0, 1'b0, 0);
      @(posedge clk_sys);
      current_threshold <= 10'h100 + (rnd() & 32'h1ff);
      press(0);
      wait_motor(1'b1, 1'b0, 40);
      chk("link_open_out", 8'h01, {7'h00, lo_out});
      wait_motor(1'b0, 1'b0, 80);
      chk("up_limit", 8'h01, {7'h00, up_lim});
      // Reverse and obstruction both send a descending arm back up
      for (int s = 4; s <= 6; s += 2) begin
         press(1);
         wait_motor(1'b0, 1'b1, 40);
         chk("link_close_out", 8'h01, {7'h00, lc_out});
         repeat (5 + (rnd() & 32'h7)) @(posedge clk_sys);
         set_in(s, 1'b1);
         wait_motor(1'b1, 1'b0, 40);
         set_in(s, 1'b0);
         wait_motor(1'b0, 1'b0, 80);
      end
      // Overcurrent while lowering reverses and locks out close
      press(1);
      wait_motor(1'b0, 1'b1, 40);
      @(posedge clk_sys);
      motor_current <= current_threshold - (rnd() & 32'h0ff) - 10'h001;
      repeat (6) @(posedge clk_sys);
      chk("motor_down", 8'h01, {7'h00, motor_down});
      motor_current <= current_threshold + 10'h001;
      wait_motor(1'b1, 1'b0, 10);
      @(posedge clk_sys);
      motor_current <= 10'h000;
      chk("close_lockout", 8'h01, {7'h00, close_lockout});
      wait_motor(1'b0, 1'b0, 80);
      press(1);
      repeat (20) @(posedge clk_sys);
      chk("motor_down", 8'h00, {7'h00, motor_down});
      press(2);
      chk("close_lockout", 8'h00, {7'h00, close_lockout});
      // Stop in mid descent, then brake choice while idle
      press(1);
      wait_motor(1'b0, 1'b1, 40);
      set_in(2, 1'b1);
      wait_motor(1'b0, 1'b0, 20);
      repeat (3) @(posedge clk_sys);
      chk("brake_on", 8'h01, {7'h00, brake_on});
      battery_variant <= 1'b1;
      option_sw <= 8'h28;
      repeat (3) @(posedge clk_sys);
      chk("brake_on", 8'h00, {7'h00, brake_on});
      set_in(2, 1'b0);
      press(0);
      wait_motor(1'b0, 1'b0, 80);
      // Auto-close: off keeps the arm up, on closes after the delay
      repeat (4 * SEC) @(posedge clk_sys);
      chk("motor_down", 8'h00, {7'h00, motor_down});
      d = 1 + (rnd() % 3);
      autoclose_delay_s <= d[6:0];
      option_sw <= 8'h09;
      n = 0;
      while (motor_down !== 1'b1 && n < 200) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk("close_early", 8'h00, {7'h00, n < (d - 1) * SEC});
      chk("close_late", 8'h00, {7'h00, n > (d + 1) * SEC + 10});
      @(posedge clk_sys);
      option_sw <= 8'h08;
      wait_motor(1'b0, 1'b0, 80);
      // Single button toggles open and close by position
      press(3);
      wait_motor(1'b1, 1'b0, 40);
      wait_motor(1'b0, 1'b0, 80);
      press(3);
      wait_motor(1'b0, 1'b1, 40);
      wait_motor(1'b0, 1'b0, 80);
      // Raise and hold, drop lowers, reset loop pauses then resumes
      set_in(5, 1'b1);
      wait_motor(1'b1, 1'b0, 40);
      wait_motor(1'b0, 1'b0, 80);
      set_in(5, 1'b0);
      wait_motor(1'b0, 1'b1, 40);
      set_in(7, 1'b1);
      wait_motor(1'b0, 1'b0, 20);
      set_in(7, 1'b0);
      wait_motor(1'b0, 1'b1, 20);
      wait_motor(1'b0, 1'b0, 80);
      // Counting: two opens need two reset loop passes before lowering
      @(posedge clk_sys);
      option_sw <= 8'h00;
      press(0);
      exp_count++;
      wait_motor(1'b1, 1'b0, 40);
      wait_motor(1'b0, 1'b0, 80);
      press(0);
      exp_count++;
      chk("vehicle_count", exp_count[7:0], vehicle_count);
      press(7);
      exp_count--;
      repeat (2) @(posedge clk_sys);
      #1;
      chk("vehicle_count", exp_count[7:0], vehicle_count);
      chk("motor_down", 8'h00, {7'h00, motor_down});
      press(7);
      exp_count--;
      wait_motor(1'b0, 1'b1, 20);
      chk("vehicle_count", exp_count[7:0], vehicle_count);
      wait_motor(1'b0, 1'b0, 80);
      // Latched raise: one pulse holds the arm up, the next lowers it
      @(posedge clk_sys);
      option_sw <= 8'h02;
      press(5);
      wait_motor(1'b1, 1'b0, 40);
      wait_motor(1'b0, 1'b0, 80);
      repeat (40) @(posedge clk_sys);
      chk("motor_down", 8'h00, {7'h00, motor_down});
      chk("vehicle_count", 8'h00, vehicle_count);
      press(5);
      wait_motor(1'b0, 1'b1, 40);
      wait_motor(1'b0, 1'b0, 80);
      // Sequenced single button: open, stop, close, stop
      @(posedge clk_sys);
      option_sw <= 8'h0c;
      seq_q = '{1, 0, 2, 0};
      while (seq_q.size() > 0) begin
         press(3);
         n = seq_q.pop_front();
         wait_motor(n[0], n[1], 40);
      end
      // Slave: local open ignored, link inputs drive, reset loop ignored
      @(posedge clk_sys);
      option_sw <= 8'h98;
      press(0);
      chk("motor_up", 8'h00, {7'h00, motor_up});
      press(8);
      wait_motor(1'b1, 1'b0, 40);
      chk("link_open_out", 8'h00, {7'h00, lo_out});
      wait_motor(1'b0, 1'b0, 80);
      press(9);
      wait_motor(1'b0, 1'b1, 40);
      chk("link_close_out", 8'h00, {7'h00, lc_out});
      set_in(7, 1'b1);
      repeat (DEB + 4) @(posedge clk_sys);
      #1;
      chk("motor_down", 8'h01, {7'h00, motor_down});
      set_in(7, 1'b0);
      wait_motor(1'b0, 1'b0, 80);
      stop_test();
   end
endmodule // tb_barrier_arm_controller
